//--- core/bmc_half_timer.sv
// half-bit timer: pulses once every programmable number of clocks
`timescale 1ns/100ps
module bmc_half_timer
  import bmc_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rstn,
  input  wire logic                 run,
  input  wire logic [BMC_DIV_W-1:0] half_div,
  output logic                      half_tick
);

  logic [BMC_DIV_W-1:0] count_reg;
  logic [BMC_DIV_W-1:0] count_next;
  wire  logic [BMC_DIV_W-1:0] limit = (half_div < BMC_HALF_DIV_MIN) ? BMC_HALF_DIV_MIN
                                                                    : half_div;
  wire  logic                 at_end = (count_reg >= limit - BMC_HALF_DIV_MIN);

  assign half_tick  = run && at_end;
  assign count_next = (!run || at_end) ? '0 : count_reg + BMC_HALF_DIV_MIN;

  always_ff @(posedge clock) begin
    if (!rstn) count_reg <= '0;
    else       count_reg <= count_next;
  end

endmodule : bmc_half_timer

//--- core/bmc_line_tx.sv
// biphase mark transmitter driving one of two configuration lines
// ---------------------------------------------------------------
// Behaviour
// - every bit period begins with a line transition.
// - a one bit adds a transition at mid period; zero does not.
// - preamble starts by driving the line low.
// - after the last bit one closing edge is sent.
// - only the orientation-selected line carries data.
// - driver enabled while sending, high impedance afterwards.
// - peak level setting held and passed to the driver.
// - only one party drives; idle driver stays high impedance.
// ---------------------------------------------------------------
`timescale 1ns/100ps
module bmc_line_tx
  import bmc_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   rstn,
  input  wire logic                   tx_start,
  input  wire logic                   tx_bit,
  input  wire logic                   tx_last,
  output logic                        tx_bit_ready,
  output logic                        tx_busy,
  input  wire logic                   orient_b,
  input  wire logic [BMC_DIV_W-1:0]   half_div,
  input  wire logic                   level_load,
  input  wire logic [BMC_LEVEL_W-1:0] level_value,
  output logic [BMC_LEVEL_W-1:0]      tx_peak_level,
  output logic                        config_line_a_out,
  output logic                        config_line_a_oe_n,
  output logic                        config_line_b_out,
  output logic                        config_line_b_oe_n
);

  // -------------------------------------------------------------
  // state and datapath registers
  // -------------------------------------------------------------
  bmc_state_t                 state_reg, state_next;
  logic                       line_reg, line_next;
  logic                       phase_reg, phase_next;
  logic                       bit_reg, bit_next;
  logic                       last_reg, last_next;
  logic                       sel_b_reg, sel_b_next;
  logic [BMC_LEVEL_W-1:0]     level_reg;
  logic                       half_tick;

  wire logic sending   = (state_reg != BMC_IDLE);
  wire logic bit_end   = half_tick && phase_reg;
  wire logic mid_point = half_tick && !phase_reg;
  wire logic idle_go   = (state_reg == BMC_IDLE) && tx_start;

  bmc_half_timer u_timer (
    .clock     (clock),
    .rstn      (rstn),
    .run       (sending),
    .half_div  (half_div),
    .half_tick (half_tick)
  );

  // the next bit is taken at each bit boundary; the user must hold it valid there
  assign tx_bit_ready = (state_reg == BMC_SEND) && bit_end && !last_reg;
  assign tx_busy      = sending;

  // -------------------------------------------------------------
  // next-state logic
  // -------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    line_next  = line_reg;
    phase_next = phase_reg;
    bit_next   = bit_reg;
    last_next  = last_reg;
    sel_b_next = sel_b_reg;
    case (state_reg)
      BMC_IDLE: begin
        line_next = 1'b1;
        if (tx_start) begin
          // first bit starts low; its leading edge off idle may be lost
          line_next  = 1'b0;
          bit_next   = tx_bit;
          last_next  = tx_last;
          sel_b_next = orient_b; // latched per packet so a frame never hops lines
          phase_next = 1'b0;
          state_next = BMC_SEND;
        end
      end
      BMC_SEND: begin
        if (mid_point) begin
          phase_next = 1'b1;
          if (bit_reg) line_next = ~line_reg;
        end else if (bit_end) begin
          phase_next = 1'b0;
          line_next  = ~line_reg;
          if (last_reg) begin
            state_next = BMC_CLOSE;
          end else begin
            bit_next  = tx_bit;
            last_next = tx_last;
          end
        end
      end
      BMC_CLOSE: begin
        // hold the closing level for half a bit so the edge is seen, then release
        if (half_tick) state_next = BMC_IDLE;
      end
      default: state_next = BMC_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg <= BMC_IDLE;
      line_reg  <= 1'b1;
      phase_reg <= 1'b0;
      bit_reg   <= 1'b0;
      last_reg  <= 1'b0;
      sel_b_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      line_reg  <= line_next;
      phase_reg <= phase_next;
      bit_reg   <= bit_next;
      last_reg  <= last_next;
      sel_b_reg <= sel_b_next;
    end
  end

  // -------------------------------------------------------------
  // peak level setting
  // -------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn)           level_reg <= BMC_LEVEL_RST;
    else if (level_load) level_reg <= level_value;
  end
  assign tx_peak_level = level_reg;

  // -------------------------------------------------------------
  // pin drive: enables are active low, unselected line stays released
  // -------------------------------------------------------------
  assign config_line_a_out  = sel_b_reg ? 1'b0 : line_reg;
  assign config_line_b_out  = sel_b_reg ? line_reg : 1'b0;
  assign config_line_a_oe_n = !(sending && !sel_b_reg);
  assign config_line_b_oe_n = !(sending && sel_b_reg);

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  a_start_low: assert property (@(posedge clock) disable iff (!rstn)
    idle_go |=> (line_reg == 1'b0) && sending)
    else $error("preamble did not start low");

  a_bound_edge: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == BMC_SEND) && bit_end |=> line_reg != $past(line_reg))
    else $error("no transition at bit boundary");

  a_mid_one: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == BMC_SEND) && mid_point && bit_reg |=> line_reg != $past(line_reg))
    else $error("one bit missing mid transition");

  a_mid_zero: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == BMC_SEND) && mid_point && !bit_reg |=> $stable(line_reg))
    else $error("zero bit has mid transition");

  a_toggle_tick: assert property (@(posedge clock) disable iff (!rstn)
    sending && !half_tick && !idle_go |=> $stable(line_reg))
    else $error("line toggled off a half-bit point");

  a_close_edge: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == BMC_SEND) && bit_end && last_reg
      |=> (state_reg == BMC_CLOSE) && (line_reg != $past(line_reg)))
    else $error("missing closing edge");

  a_one_line: assert property (@(posedge clock) disable iff (!rstn)
    config_line_a_oe_n || config_line_b_oe_n)
    else $error("both lines driven");

  a_idle_hiz: assert property (@(posedge clock) disable iff (!rstn)
    !sending |-> config_line_a_oe_n && config_line_b_oe_n)
    else $error("idle driver not released");

  a_release: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == BMC_CLOSE) && half_tick |=> config_line_a_oe_n && config_line_b_oe_n)
    else $error("driver not released after close");

  a_level_hold: assert property (@(posedge clock) disable iff (!rstn)
    level_load |=> tx_peak_level == $past(level_value))
    else $error("peak level not loaded");

  // orientation may move mid packet; the latched select must not follow it
  a_sel_hold: assert property (@(posedge clock) disable iff (!rstn)
    sending |=> !sending || $stable(sel_b_reg))
    else $error("line select changed inside a packet");

  // while sending exactly one line is driven, never none
  a_drive_one: assert property (@(posedge clock) disable iff (!rstn)
    sending |-> (config_line_a_oe_n != config_line_b_oe_n))
    else $error("no single line driven while sending");

  // one sample per bit; a double pulse would swallow a bit
  a_ready_pulse: assert property (@(posedge clock) disable iff (!rstn)
    tx_bit_ready |=> !tx_bit_ready)
    else $error("bit request longer than one cycle");

  // only the single closing edge; the line rests until release
  a_close_quiet: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == BMC_CLOSE) |=> $stable(line_reg))
    else $error("extra edge after closing edge");

  // -------------------------------------------------------------
  // coverage of the main scenarios
  // -------------------------------------------------------------
  c_one_bit: cover property (@(posedge clock) disable iff (!rstn)
    (state_reg == BMC_SEND) && mid_point && bit_reg);
  c_zero_bit: cover property (@(posedge clock) disable iff (!rstn)
    (state_reg == BMC_SEND) && mid_point && !bit_reg);
  c_close: cover property (@(posedge clock) disable iff (!rstn)
    (state_reg == BMC_CLOSE) && half_tick);
  c_line_b: cover property (@(posedge clock) disable iff (!rstn)
    !config_line_b_oe_n);
  c_level_load: cover property (@(posedge clock) disable iff (!rstn)
    level_load);

endmodule : bmc_line_tx

//--- core/bmc_pkg.sv
// package of constants and types for the bmc line transmitter
package bmc_pkg;

  localparam int          BMC_DIV_W        = 12;
  localparam int          BMC_LEVEL_W      = 4;
  localparam logic [11:0] BMC_HALF_DIV_RST = 12'h03E;
  localparam logic [3:0]  BMC_LEVEL_RST    = 4'h8;
  localparam logic [11:0] BMC_HALF_DIV_MIN = 12'h001;

  typedef enum logic [1:0] {
    BMC_IDLE,
    BMC_SEND,
    BMC_CLOSE
  } bmc_state_t;

endpackage : bmc_pkg

//--- verif/bmc_rx_model.sv
// partner receiver model: decodes biphase mark traffic seen on one line
`timescale 1ns/100ps
module bmc_rx_model (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [11:0] half_div,
  input  wire logic        line,
  input  wire logic        oe_n,
  output logic [31:0]      word,
  output int               nbits,
  output logic             bad,
  output logic             drove
);
  int   cnt;
  logic half, prev, on;
  always @(posedge clock) begin
    if (!rstn) begin
      bad   <= 1'b0;
      drove <= 1'b0;
      on    <= 1'b0;
    end else if (!oe_n) begin
      drove <= 1'b1;
      on    <= 1'b1;
      prev  <= line;
      cnt   <= cnt + 1;
      // no start edge needed: the edge out of the bias may be lost
      if (!on) begin
        word  <= '0;
        nbits <= 0;
        half  <= 1'b0;
        cnt   <= 1;
        bad   <= bad | (line !== 1'b0);
      end else if (line != prev) begin
        cnt <= 1;
        if (cnt == 2 * half_div && !half) begin
          word  <= {word[30:0], 1'b0};
          nbits <= nbits + 1;
        end else if (cnt == half_div && !half) half <= 1'b1;
        else if (cnt == half_div) begin
          word  <= {word[30:0], 1'b1};
          nbits <= nbits + 1;
          half  <= 1'b0;
        end else bad <= 1'b1;
      end
    end else on <= 1'b0;
  end
endmodule : bmc_rx_model

//--- verif/tb.sv
// self-checking bench for the biphase mark line transmitter
`timescale 1ns/100ps
module tb;
  import bmc_pkg::*;
  logic                   clock = 0, rstn = 0, tx_start = 0, tx_bit = 0, tx_last = 0;
  logic                   orient_b = 0, level_load = 0;
  logic [BMC_DIV_W-1:0]   half_div = 12'h003;
  logic [BMC_LEVEL_W-1:0] level_value = 4'h0, peak;
  logic                   rdy, busy, a_out, a_oe_n, b_out, b_oe_n;
  logic                   bad_a, bad_b, dr_a, dr_b;
  logic [31:0]            wa, wb;
  int                     na, nb, fails = 0, n_checks = 0, cyc = 0;
  // released lines float back to the high bias level
  wire line_a = a_oe_n ? 1'b1 : a_out;
  wire line_b = b_oe_n ? 1'b1 : b_out;
  always #12.5 clock = ~clock;
  bmc_line_tx i_dut (.clock(clock), .rstn(rstn), .tx_start(tx_start), .tx_bit(tx_bit),
    .tx_last(tx_last), .tx_bit_ready(rdy), .tx_busy(busy), .orient_b(orient_b),
    .half_div(half_div), .level_load(level_load), .level_value(level_value),
    .tx_peak_level(peak), .config_line_a_out(a_out), .config_line_a_oe_n(a_oe_n),
    .config_line_b_out(b_out), .config_line_b_oe_n(b_oe_n));
  bmc_rx_model i_rx_a (.clock(clock), .rstn(rstn), .half_div(half_div), .line(line_a),
    .oe_n(a_oe_n), .word(wa), .nbits(na), .bad(bad_a), .drove(dr_a));
  bmc_rx_model i_rx_b (.clock(clock), .rstn(rstn), .half_div(half_div), .line(line_b),
    .oe_n(b_oe_n), .word(wb), .nbits(nb), .bad(bad_b), .drove(dr_b));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic do_reset;
    rstn = 0;
    repeat (5) @(negedge clock);
    rstn = 1;
    chk({peak, a_oe_n, b_oe_n, busy, rdy}, {BMC_LEVEL_RST, 4'b1100});
  endtask : do_reset
  // orientation is flipped after the start to show it is held per packet
  task automatic send(input logic ob, input logic [31:0] b, input int n);
    int   i;
    int   k;
    logic adv;
    @(negedge clock);
    orient_b = ob;
    tx_start = 1;
    tx_bit   = b[n-1];
    tx_last  = (n == 1);
    @(negedge clock);
    tx_start = 0;
    orient_b = ~ob;
    i        = n - 1;
    adv      = 0;
    k        = 0;
    chk({ob ? b_oe_n : a_oe_n, ob ? b_out : a_out, busy}, 3'b001);
    repeat (400) begin
      if (adv) i--;
      if (i > 0) begin
        tx_bit  = b[i-1];
        tx_last = (i == 1);
      end
      // a start request while busy must be ignored
      if (k == 3) tx_start = 1;
      if (k == 4) tx_start = 0;
      k++;
      adv = rdy;
      @(negedge clock);
      if (!busy) break;
    end
    tx_start = 0;
    chk(ob ? wb : wa, b & ((32'h1 << n) - 1));
    chk(ob ? nb : na, n);
    chk({bad_a, bad_b, a_oe_n, b_oe_n, busy}, 5'b00110);
  endtask : send
  task automatic level_test;
    level_value = 4'h5;
    level_load  = 1;
    @(negedge clock);
    level_load  = 0;
    level_value = 4'hA;
    chk(peak, 4'h5);
    @(negedge clock);
    chk(peak, 4'h5);
    level_load  = 1;
    @(negedge clock);
    level_load  = 0;
    chk(peak, 4'hA);
  endtask : level_test
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    do_reset();
    send(1'b0, 32'h000000B2, 8);
    send(1'b0, 32'h00000001, 1);
    chk(dr_b, 1'b0);
    half_div = 12'h002;
    do_reset();
    send(1'b1, 32'h0000035A, 10);
    chk(dr_a, 1'b0);
    level_test();
    conclude();
  end
endmodule : tb
